// ==== rtl/pin_opt_consts.svh ====
// offsets, field positions, reset values and encodings of the pin and serial option registers
//
// What this block does
// [RQ1] bit0 one makes pin input, zero output
// [RQ2] bit1 one inverts pin logic sense
// [RQ3] bit7 selects open-drain or push-pull driver
// [RQ4] pins 1.6/1.7 bit2 joins port3 handshake
// [RQ5] pin 2.1 field: keyboard data, edge irq0
// [RQ6] pin 2.2 field: keyboard clock, edge irq1
// [RQ7] software keeps pin 2.1 output for keyboard
// [RQ8] software keeps pin 2.2 output for keyboard
// [RQ9] read-only mirror of port5 fifo control
// [RQ10] read-only mirror of port6 fifo control
// [RQ11] option routes spare output and spare input
// [RQ12] option enables auto direction, picks its signal
// [RQ13] option bit5 sets direction signal level
// [RQ14] reserved bits read zero, writes ignored
`ifndef PIN_OPT_CONSTS_SVH
`define PIN_OPT_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_PIN_1_6       8'h2a
`define OFS_PIN_1_7       8'h2b
`define OFS_PIN_2_1       8'h2c
`define OFS_PIN_2_2       8'h2d
`define OFS_P5_FIFO_MIR   8'h2e
`define OFS_P6_FIFO_MIR   8'h2f
`define OFS_P5_OPTIONS    8'h30
`define OFS_IRQ_STATUS    8'h3e
`define OFS_IRQ_MASK      8'h3f

// ---------------------------------------------------------------
// reset values, writable-bit masks and the fifo mirror read mask
// ---------------------------------------------------------------
`define RST_PIN_1_X       8'h01
`define RST_PIN_2_X       8'h8c
`define RST_P5_OPTIONS    8'h04
`define WMASK_PIN_1_X     8'h87
`define WMASK_PIN_2_X     8'h8f
`define WMASK_OPTIONS     8'h3f
`define RMASK_FIFO_MIR    8'hcf
`define WMASK_IRQ         8'h03

// ---------------------------------------------------------------
// alternate function encodings of pins 2.1 and 2.2, and port5 spare input selects
// ---------------------------------------------------------------
`define ALT_KEYBOARD      2'h3
`define ALT_EDGE_IRQ      2'h2
`define SPARE_IN_DCD      2'h3
`define SPARE_IN_RI       2'h2
`define SPARE_IN_CTS      2'h1
`define SPARE_IN_DSR      2'h0

// status and mask bit positions
`define IRQ_BIT_EDGE0     0
`define IRQ_BIT_EDGE1     1

`endif

// ==== rtl/pin_opt_pkg.sv ====
// field layouts of the pin and serial option registers
package pin_opt_pkg;

   typedef struct packed {
      logic       openDrain;
      logic [2:0] rsvd;
      logic [1:0] altSel;
      logic       invert;
      logic       isInput;
   } pin_cfg_t;

   typedef struct packed {
      logic [1:0] rxTrigger;
      logic [1:0] rsvd;
      logic       dmaMode;
      logic       txReset;
      logic       rxReset;
      logic       enable;
   } fifo_shadow_t;

   typedef struct packed {
      logic [1:0] rsvd;
      logic       activeHigh;
      logic       useRts;
      logic       autoDir;
      logic [1:0] spareInSel;
      logic       spareOutRts;
   } serial_opt_t;

endpackage : pin_opt_pkg

// ==== rtl/pin_cell.sv ====
// one configurable pin: direction, polarity, driver type, input synchroniser
`timescale 1ns/1ps
module pin_cell
   import pin_opt_pkg::*;
(
   input  wire logic     ref_clk,
   input  wire logic     reset,
   input  wire pin_cfg_t cfg,
   input  wire logic     useAlt,
   input  wire logic     altOut,
   input  wire logic     gpioOut,
   input  wire logic     pinIn,
   output logic          pinOut,
   output logic          pinOe,
   output logic          levelIn
);

   logic sync1_q, sync2_q, sync1_d, sync2_d;
   logic pinOut_d, pinOe_d, levelIn_d, drive;

   // ---------------------------------------------------------------
   // driver and input path
   // ---------------------------------------------------------------
   // polarity applies to both directions so software sees one sense
   always_comb begin
      drive     = (useAlt ? altOut : gpioOut) ^ cfg.invert;    // [RQ2]
      sync1_d   = pinIn;
      sync2_d   = sync1_q;
      levelIn_d = sync2_q ^ cfg.invert;                        // [RQ2]
      if (cfg.isInput) begin                                   // [RQ1]
         pinOe_d  = 1'b0;
         pinOut_d = 1'b0;
      end else if (cfg.openDrain) begin                        // [RQ3]
         pinOe_d  = ~drive;                                    // only pulls low
         pinOut_d = 1'b0;
      end else begin
         pinOe_d  = 1'b1;
         pinOut_d = drive;
      end
   end

   always_ff @(posedge ref_clk) begin
      // pins idle high on their pull-ups; starting low gave a false keyboard edge
      if (reset) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         pinOut  <= 1'b0;
         pinOe   <= 1'b0;
         levelIn <= 1'b1;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         pinOut  <= pinOut_d;
         pinOe   <= pinOe_d;
         levelIn <= levelIn_d;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_input_floats;                                    // [RQ1]
      @(posedge ref_clk) disable iff (reset)
      cfg.isInput |=> !pinOe && !pinOut;
   endproperty
   a_input_floats: assert property (p_input_floats)            // [RQ1]
      else $error("input pin is driven");

   property p_push_pull_level;                                 // [RQ2]
      @(posedge ref_clk) disable iff (reset)
      (!cfg.isInput && !cfg.openDrain)
         |=> pinOe && (pinOut == ($past(useAlt ? altOut : gpioOut) ^ $past(cfg.invert)));
   endproperty
   a_push_pull_level: assert property (p_push_pull_level)      // [RQ2]
      else $error("push-pull level wrong");

   property p_open_drain_low_only;                             // [RQ3]
      @(posedge ref_clk) disable iff (reset)
      (!cfg.isInput && cfg.openDrain)
         |=> !pinOut && (pinOe == !($past(useAlt ? altOut : gpioOut) ^ $past(cfg.invert)));
   endproperty
   a_open_drain_low_only: assert property (p_open_drain_low_only) // [RQ3]
      else $error("open-drain pin drives high or wrong enable");

endmodule : pin_cell

// ==== rtl/edge_event.sv ====
// either-edge detector producing a one-cycle event pulse
`timescale 1ns/1ps
module edge_event (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic level,
   input  wire logic enable,
   output logic      edgePulse
);

   logic prev_q, prev_d, edgePulse_d;

   // prev tracks level always, so enabling never fires a stale edge
   always_comb begin
      prev_d      = level;
      edgePulse_d = enable & (level ^ prev_q);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prev_q    <= 1'b1;
         edgePulse <= 1'b0;
      end else begin
         prev_q    <= prev_d;
         edgePulse <= edgePulse_d;
      end
   end

endmodule : edge_event

// ==== rtl/runtime_pin_and_serial_option_regs.sv ====
// runtime register slice: four pin configs, two fifo mirrors, port5 options, edge irqs
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "pin_opt_consts.svh"
module runtime_pin_and_serial_option_regs
   import pin_opt_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         reset,
   input  wire logic [7:0]   regAddr,
   input  wire logic [7:0]   regWrData,
   input  wire logic         regWrStrobe,
   input  wire logic         regRdStrobe,
   output logic [7:0]        regRdData,
   input  wire logic [3:0]   pinIn,
   output logic [3:0]        pinOut,
   output logic [3:0]        pinOe,
   input  wire logic [3:0]   gpioOutData,
   output logic [3:0]        gpioInData,
   input  wire logic         port3RequestToSend,
   output logic              port3ClearToSend,
   input  wire logic         keyboardDataDrive,
   input  wire logic         keyboardClockDrive,
   output logic              keyboardDataLine,
   output logic              keyboardClockLine,
   input  wire fifo_shadow_t port5FifoShadow,
   input  wire fifo_shadow_t port6FifoShadow,
   input  wire logic         port5RequestToSend,
   input  wire logic         port5TerminalReady,
   input  wire logic         port5TxActive,
   output logic              port5RtsOut,
   output logic              port5DtrOut,
   output logic              port5SpareOutput,
   input  wire logic         port5SpareIn,
   output logic              port5CarrierDetect,
   output logic              port5RingIndicator,
   output logic              port5ClearToSend,
   output logic              port5SetReady,
   output logic              irq
);

   // index 0 = pin 1.6, 1 = pin 1.7, 2 = pin 2.1, 3 = pin 2.2
   pin_cfg_t    cfg_q [4];
   pin_cfg_t    cfg_d [4];
   serial_opt_t opt_q, opt_d;
   logic [1:0]  irqStatus_q, irqStatus_d, irqMask_q, irqMask_d;
   logic [7:0]  rdData_d;
   logic [3:0]  useAlt, altOut, levelIn;
   logic [1:0]  edgeHit;
   logic        spare1_q, spare2_q, spare1_d, spare2_d;
   logic        irq_d, cts3_d, kbdData_d, kbdClock_d;
   logic        rts5_d, dtr5_d, dirLevel, spareOut_d;
   logic        cd5_d, ri5_d, cts5_d, dsr5_d;

   // keep only defined bits so reserved ones always read back zero
   function automatic logic [7:0] wr_field(input logic [7:0] data, input logic [7:0] mask);
      wr_field = data & mask;                                  // [RQ14]
   endfunction : wr_field

   function automatic logic hit(input logic [7:0] ofs);
      hit = regWrStrobe && (regAddr == ofs);
   endfunction : hit

   // ---------------------------------------------------------------
   // register writes and event status
   // ---------------------------------------------------------------
   always_comb begin
      cfg_d = cfg_q;
      opt_d = opt_q;
      irqMask_d = irqMask_q;
      irqStatus_d = irqStatus_q;
      if (hit(`OFS_PIN_1_6)) cfg_d[0] = wr_field(regWrData, `WMASK_PIN_1_X); // [RQ14]
      if (hit(`OFS_PIN_1_7)) cfg_d[1] = wr_field(regWrData, `WMASK_PIN_1_X);
      if (hit(`OFS_PIN_2_1)) cfg_d[2] = wr_field(regWrData, `WMASK_PIN_2_X);
      if (hit(`OFS_PIN_2_2)) cfg_d[3] = wr_field(regWrData, `WMASK_PIN_2_X);
      if (hit(`OFS_P5_OPTIONS)) opt_d = wr_field(regWrData, `WMASK_OPTIONS); // [RQ14]
      if (hit(`OFS_IRQ_MASK)) irqMask_d = regWrData[1:0];
      // write-one clears, then a same-cycle event sets again: set wins
      if (hit(`OFS_IRQ_STATUS)) irqStatus_d = irqStatus_q & ~regWrData[1:0];
      irqStatus_d = irqStatus_d | edgeHit;                     // [RQ5] [RQ6]
      irq_d = |(irqStatus_d & irqMask_d);
   end

   // ---------------------------------------------------------------
   // read mux; mirrors and unmapped offsets read through the same path
   // ---------------------------------------------------------------
   always_comb begin
      rdData_d = regRdData;
      if (regRdStrobe) begin
         case (regAddr)
            `OFS_PIN_1_6:     rdData_d = cfg_q[0];
            `OFS_PIN_1_7:     rdData_d = cfg_q[1];
            `OFS_PIN_2_1:     rdData_d = cfg_q[2];
            `OFS_PIN_2_2:     rdData_d = cfg_q[3];
            `OFS_P5_FIFO_MIR: rdData_d = port5FifoShadow & `RMASK_FIFO_MIR; // [RQ9] [RQ14]
            `OFS_P6_FIFO_MIR: rdData_d = port6FifoShadow & `RMASK_FIFO_MIR; // [RQ10] [RQ14]
            `OFS_P5_OPTIONS:  rdData_d = opt_q;
            `OFS_IRQ_STATUS:  rdData_d = {6'h00, irqStatus_q};
            `OFS_IRQ_MASK:    rdData_d = {6'h00, irqMask_q};
            default:          rdData_d = 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // alternate function steering for the pins
   // ---------------------------------------------------------------
   // edge-irq mode leaves the pin a plain gpio so software still owns drive
   always_comb begin
      useAlt[0] = 1'b0;                                        // cts3 is an input only
      altOut[0] = 1'b1;
      useAlt[1] = cfg_q[1].altSel[0];                          // [RQ4]
      altOut[1] = port3RequestToSend;
      useAlt[2] = (cfg_q[2].altSel == `ALT_KEYBOARD);          // [RQ5]
      altOut[2] = keyboardDataDrive;
      useAlt[3] = (cfg_q[3].altSel == `ALT_KEYBOARD);          // [RQ6]
      altOut[3] = keyboardClockDrive;
      // unselected handshake and keyboard inputs idle high (inactive)
      cts3_d     = cfg_q[0].altSel[0] ? levelIn[0] : 1'b1;     // [RQ4]
      kbdData_d  = useAlt[2] ? levelIn[2] : 1'b1;              // [RQ5]
      kbdClock_d = useAlt[3] ? levelIn[3] : 1'b1;              // [RQ6]
   end

   for (genvar i = 0; i < 4; i++) begin : g_pin
      pin_cell u_pin (
         .ref_clk (ref_clk),
         .reset   (reset),
         .cfg     (cfg_q[i]),
         .useAlt  (useAlt[i]),
         .altOut  (altOut[i]),
         .gpioOut (gpioOutData[i]),
         .pinIn   (pinIn[i]),
         .pinOut  (pinOut[i]),
         .pinOe   (pinOe[i]),
         .levelIn (levelIn[i])
      );
   end

   for (genvar e = 0; e < 2; e++) begin : g_edge
      edge_event u_edge (
         .ref_clk   (ref_clk),
         .reset     (reset),
         .level     (levelIn[e + 2]),
         .enable    (cfg_q[e + 2].altSel == `ALT_EDGE_IRQ), // [RQ5] [RQ6]
         .edgePulse (edgeHit[e])
      );
   end

   // ---------------------------------------------------------------
   // serial port five: spare signals and automatic direction
   // ---------------------------------------------------------------
   // direction level follows transmit activity; idle gives the opposite level
   always_comb begin
      spare1_d = port5SpareIn;
      spare2_d = spare1_q;
      dirLevel = port5TxActive ? opt_q.activeHigh : ~opt_q.activeHigh; // [RQ13]
      rts5_d = port5RequestToSend;
      dtr5_d = port5TerminalReady;
      if (opt_q.autoDir) begin                                 // [RQ12]
         if (opt_q.useRts) begin
            rts5_d = dirLevel;
         end else begin
            dtr5_d = dirLevel;
         end
      end
      spareOut_d = opt_q.spareOutRts ? rts5_d : dtr5_d;        // [RQ11]
      cd5_d  = (opt_q.spareInSel == `SPARE_IN_DCD) ? spare2_q : 1'b1; // [RQ11]
      ri5_d  = (opt_q.spareInSel == `SPARE_IN_RI)  ? spare2_q : 1'b1;
      cts5_d = (opt_q.spareInSel == `SPARE_IN_CTS) ? spare2_q : 1'b1;
      dsr5_d = (opt_q.spareInSel == `SPARE_IN_DSR) ? spare2_q : 1'b1;
   end

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_q[0]    <= `RST_PIN_1_X;
         cfg_q[1]    <= `RST_PIN_1_X;
         cfg_q[2]    <= `RST_PIN_2_X;
         cfg_q[3]    <= `RST_PIN_2_X;
         opt_q       <= `RST_P5_OPTIONS;
         irqStatus_q <= 2'h0;
         irqMask_q   <= 2'h0;
         regRdData   <= 8'h00;
         irq         <= 1'b0;
         spare1_q    <= 1'b1;
         spare2_q    <= 1'b1;
         gpioInData  <= 4'h0;
         port3ClearToSend   <= 1'b1;
         keyboardDataLine   <= 1'b1;
         keyboardClockLine  <= 1'b1;
         port5RtsOut        <= 1'b1;
         port5DtrOut        <= 1'b1;
         port5SpareOutput   <= 1'b1;
         port5CarrierDetect <= 1'b1;
         port5RingIndicator <= 1'b1;
         port5ClearToSend   <= 1'b1;
         port5SetReady      <= 1'b1;
      end else begin
         cfg_q       <= cfg_d;
         opt_q       <= opt_d;
         irqStatus_q <= irqStatus_d;
         irqMask_q   <= irqMask_d;
         regRdData   <= rdData_d;
         irq         <= irq_d;
         spare1_q    <= spare1_d;
         spare2_q    <= spare2_d;
         gpioInData  <= levelIn;
         port3ClearToSend   <= cts3_d;
         keyboardDataLine   <= kbdData_d;
         keyboardClockLine  <= kbdClock_d;
         port5RtsOut        <= rts5_d;
         port5DtrOut        <= dtr5_d;
         port5SpareOutput   <= spareOut_d;
         port5CarrierDetect <= cd5_d;
         port5RingIndicator <= ri5_d;
         port5ClearToSend   <= cts5_d;
         port5SetReady      <= dsr5_d;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_cts3_idle;
      @(posedge ref_clk) disable iff (reset)
      !cfg_q[0].altSel[0] |=> port3ClearToSend;
   endproperty
   a_cts3_idle: assert property (p_cts3_idle) // [RQ4]
      else $error("cts3 not idle while pin 1.6 is gpio");

   property p_edge0_sets;
      @(posedge ref_clk) disable iff (reset)
      edgeHit[0] |=> irqStatus_q[0] && (irq || !irqMask_q[0]);
   endproperty
   a_edge0_sets: assert property (p_edge0_sets) // [RQ5]
      else $error("edge on pin 2.1 lost");

   property p_kbd_clock_follows;
      @(posedge ref_clk) disable iff (reset)
      (cfg_q[3].altSel == `ALT_KEYBOARD) |=> keyboardClockLine == $past(levelIn[3]);
   endproperty
   a_kbd_clock_follows: assert property (p_kbd_clock_follows) // [RQ6]
      else $error("keyboard clock line not routed");

   property p_fifo5_mirror;
      @(posedge ref_clk) disable iff (reset)
      (regRdStrobe && regAddr == `OFS_P5_FIFO_MIR)
         |=> regRdData == ($past(port5FifoShadow) & `RMASK_FIFO_MIR);
   endproperty
   a_fifo5_mirror: assert property (p_fifo5_mirror) // [RQ9]
      else $error("port5 fifo mirror wrong");

   property p_fifo6_mirror;
      @(posedge ref_clk) disable iff (reset)
      (regRdStrobe && regAddr == `OFS_P6_FIFO_MIR)
         |=> regRdData[7:6] == $past(port6FifoShadow.rxTrigger) && regRdData[5:4] == 2'h0;
   endproperty
   a_fifo6_mirror: assert property (p_fifo6_mirror) // [RQ10]
      else $error("port6 fifo mirror wrong");

   property p_spare_dcd;
      @(posedge ref_clk) disable iff (reset)
      (opt_q.spareInSel == `SPARE_IN_DCD) |=> port5CarrierDetect == $past(spare2_q)
         && port5SetReady;
   endproperty
   a_spare_dcd: assert property (p_spare_dcd) // [RQ11]
      else $error("spare input misrouted");

   property p_auto_dir_rts;
      @(posedge ref_clk) disable iff (reset)
      (opt_q.autoDir && opt_q.useRts && port5TxActive)
         |=> port5RtsOut == $past(opt_q.activeHigh) && port5DtrOut == $past(port5TerminalReady);
   endproperty
   a_auto_dir_rts: assert property (p_auto_dir_rts) // [RQ12]
      else $error("auto direction on rts wrong");

   property p_auto_dir_idle;
      @(posedge ref_clk) disable iff (reset)
      (opt_q.autoDir && !opt_q.useRts && !port5TxActive)
         |=> port5DtrOut == !$past(opt_q.activeHigh);
   endproperty
   a_auto_dir_idle: assert property (p_auto_dir_idle) // [RQ13]
      else $error("idle direction level wrong");

   property p_reserved_zero;
      @(posedge ref_clk) disable iff (reset)
      (regRdStrobe && regAddr == `OFS_PIN_2_1) |=> regRdData[6:4] == 3'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // [RQ14]
      else $error("reserved bits read nonzero");

endmodule : runtime_pin_and_serial_option_regs

// ==== testbench/pin_world.sv ====
// far side of the four pins: board pull-ups plus one external driver per pin
`timescale 1ns/1ps
module pin_world (
   input  wire logic [3:0] pinOut,
   input  wire logic [3:0] pinOe,
   input  wire logic [3:0] extEn,
   input  wire logic [3:0] extVal,
   output logic [3:0]      pinIn
);
   // ---------------------------------------------------------------
   // wire level
   // ---------------------------------------------------------------
   // chip wins while driving; a released line takes the external driver if enabled, else the pull-up
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pinIn[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'b1);
      end
   end
endmodule : pin_world

// ==== testbench/runtime_pin_and_serial_option_regs_tb_top.sv ====
// self-checking bench for the pin and serial option register slice
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errTotal++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end
module runtime_pin_and_serial_option_regs_tb_top
   import pin_opt_pkg::*;
;
   logic         ref_clk = 1'b0;
   logic         reset = 1'b1;
   logic [7:0]   regAddr = 8'h00;
   logic [7:0]   regWrData = 8'h00;
   logic         regWrStrobe = 1'b0;
   logic         regRdStrobe = 1'b0;
   logic [7:0]   regRdData;
   logic [3:0]   pinIn, pinOut, pinOe, gpioInData;
   logic [3:0]   gpioOutData = 4'hf;
   logic [3:0]   extEn = 4'h0;
   logic [3:0]   extVal = 4'hf;
   logic         port3RequestToSend = 1'b1;
   logic         port3ClearToSend, keyboardDataLine, keyboardClockLine;
   logic         keyboardDataDrive = 1'b1;
   logic         keyboardClockDrive = 1'b1;
   fifo_shadow_t port5FifoShadow = 8'hff;
   fifo_shadow_t port6FifoShadow = 8'h5a;
   logic         port5RequestToSend = 1'b0;
   logic         port5TerminalReady = 1'b1;
   logic         port5TxActive = 1'b0;
   logic         port5SpareIn = 1'b1;
   logic         port5RtsOut, port5DtrOut, port5SpareOutput, irq;
   logic         port5CarrierDetect, port5RingIndicator, port5ClearToSend, port5SetReady;
   // grouped port5 outputs keep the compare lines short
   wire [3:0]    spareIns = {port5CarrierDetect, port5RingIndicator,
                             port5ClearToSend, port5SetReady};
   wire [2:0]    dirOuts = {port5RtsOut, port5DtrOut, port5SpareOutput};
   int           errTotal = 0;
   int           checks = 0;
   int           cycleCount = 0;
   // reset values; mirrors show live shadows with bits 5:4 dropped, unmapped reads zero
   logic [7:0]   rstAddr [10] = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h3e,
                                  8'h3f, 8'h00};
   logic [7:0]   rstVal [10] = '{8'h01, 8'h01, 8'h8c, 8'h8c, 8'hcf, 8'h4a, 8'h04, 8'h00,
                                 8'h00, 8'h00};
   // pin 1.6 driver cases as {cfg, oe, out} with drive one
   logic [9:0]   pinTab [5] = '{{8'h00, 2'b11}, {8'h02, 2'b10}, {8'h80, 2'b00},
                                {8'h82, 2'b10}, {8'h01, 2'b00}};
   // direction control cases as {option, txActive, rts, dtr, spare}
   logic [11:0]  optTab [5] = '{{8'h18, 4'b1011}, {8'h18, 4'b0111}, {8'h28, 4'b0000},
                                {8'h30, 4'b1011}, {8'h39, 4'b1111}};

   // ---------------------------------------------------------------
   // clock, instances and watchdog
   // ---------------------------------------------------------------
   always #2 ref_clk = ~ref_clk;

   runtime_pin_and_serial_option_regs runtime_pin_and_serial_option_regs_i (
      .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .gpioOutData(gpioOutData),
      .gpioInData(gpioInData), .port3RequestToSend(port3RequestToSend),
      .port3ClearToSend(port3ClearToSend), .keyboardDataDrive(keyboardDataDrive),
      .keyboardClockDrive(keyboardClockDrive), .keyboardDataLine(keyboardDataLine),
      .keyboardClockLine(keyboardClockLine), .port5FifoShadow(port5FifoShadow),
      .port6FifoShadow(port6FifoShadow), .port5RequestToSend(port5RequestToSend),
      .port5TerminalReady(port5TerminalReady), .port5TxActive(port5TxActive),
      .port5RtsOut(port5RtsOut), .port5DtrOut(port5DtrOut),
      .port5SpareOutput(port5SpareOutput), .port5SpareIn(port5SpareIn),
      .port5CarrierDetect(port5CarrierDetect), .port5RingIndicator(port5RingIndicator),
      .port5ClearToSend(port5ClearToSend), .port5SetReady(port5SetReady), .irq(irq));

   pin_world pin_world_i (
      .pinOut(pinOut), .pinOe(pinOe), .extEn(extEn), .extVal(extVal), .pinIn(pinIn));

   // a hang counts as a mismatch and still ends in the verdict
   always @(posedge ref_clk) begin
      cycleCount++;
      if (cycleCount == 4000) begin
         errTotal++;
         stopTest();
      end
   end

   // ---------------------------------------------------------------
   // bus and helper tasks
   // ---------------------------------------------------------------
   task automatic stopTest;
      if (errTotal == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stopTest

   // settle covers register, output flop and the three-flop input path
   task automatic settle;
      repeat (6) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWrStrobe <= 1'b1;
      regAddr     <= a;
      regWrData   <= d;
      @(posedge ref_clk);
      regWrStrobe <= 1'b0;
      settle();
   endtask : wr

   // read data appear in the cycle after the strobe and hold until the next read
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] got;
      @(posedge ref_clk);
      regRdStrobe <= 1'b1;
      regAddr     <= a;
      @(posedge ref_clk);
      regRdStrobe <= 1'b0;
      #1;
      got = regRdData;
      `CHK("regRdData", e, got)
   endtask : rdChk

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 10; i++) rdChk(rstAddr[i], rstVal[i]);
      wr(8'h2b, 8'hff);
      rdChk(8'h2b, 8'h87);
      wr(8'h2d, 8'hff);
      rdChk(8'h2d, 8'h8f);
      wr(8'h30, 8'hff);
      rdChk(8'h30, 8'h3f);
      wr(8'h2e, 8'h00);
      rdChk(8'h2e, 8'hcf);
      // driver type, polarity and direction on pin 1.6
      for (int i = 0; i < 5; i++) begin
         wr(8'h2a, pinTab[i][9:2]);
         `CHK("pin16", pinTab[i][1:0], {pinOe[0], pinOut[0]})
      end
      extEn[0]  <= 1'b1;
      extVal[0] <= 1'b0;
      wr(8'h2a, 8'h01);
      `CHK("gpioIn0", 1'b0, gpioInData[0])
      wr(8'h2a, 8'h03);
      `CHK("gpioIn0", 1'b1, gpioInData[0])
      // third port handshake on pins 1.6 and 1.7
      wr(8'h2a, 8'h05);
      `CHK("cts3", 1'b0, port3ClearToSend)
      wr(8'h2a, 8'h01);
      `CHK("cts3", 1'b1, port3ClearToSend)
      gpioOutData <= 4'h0;
      wr(8'h2b, 8'h04);
      `CHK("pin17", 2'b11, {pinOe[1], pinOut[1]})
      wr(8'h2b, 8'h00);
      `CHK("pin17", 2'b10, {pinOe[1], pinOut[1]})
      // keyboard lines: 2.1 push-pull, 2.2 back to its open-drain default
      wr(8'h2c, 8'h0c);
      wr(8'h2d, 8'h8c);
      keyboardDataDrive  <= 1'b0;
      keyboardClockDrive <= 1'b0;
      settle();
      `CHK("kbdData", 3'b100, {pinOe[2], pinOut[2], keyboardDataLine})
      `CHK("kbdClk", 3'b100, {pinOe[3], pinOut[3], keyboardClockLine})
      keyboardDataDrive  <= 1'b1;
      keyboardClockDrive <= 1'b1;
      settle();
      `CHK("kbdData", 3'b111, {pinOe[2], pinOut[2], keyboardDataLine})
      `CHK("kbdClk", 3'b001, {pinOe[3], pinOut[3], keyboardClockLine})
      // edge interrupts: raise, mask, clear
      extEn[3:2] <= 2'b11;
      wr(8'h2c, 8'h09);
      wr(8'h2d, 8'h09);
      wr(8'h3f, 8'h01);
      extVal[2] <= 1'b0;
      settle();
      `CHK("irq", 1'b1, irq)
      extVal[3] <= 1'b0;
      settle();
      rdChk(8'h3e, 8'h03);
      wr(8'h3e, 8'h01);
      `CHK("irq", 1'b0, irq)
      wr(8'h3f, 8'h03);
      `CHK("irq", 1'b1, irq)
      wr(8'h3e, 8'h02);
      wr(8'h2c, 8'h01);
      extVal[2] <= 1'b1;
      settle();
      rdChk(8'h3e, 8'h00);
      `CHK("irq", 1'b0, irq)
      // spare output and spare input routing
      wr(8'h30, 8'h01);
      `CHK("spareOut", 1'b0, port5SpareOutput)
      port5SpareIn <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         wr(8'h30, 8'(s << 1));
         `CHK("spareIn", ~(4'h1 << s), spareIns)
      end
      // automatic direction control: enable, signal choice, active level
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk);
         port5TxActive <= optTab[i][3];
         wr(8'h30, optTab[i][11:4]);
         `CHK("autoDir", optTab[i][2:0], dirOuts)
      end
      // a second reset restores the option register
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      rdChk(8'h30, 8'h04);
      stopTest();
   end
endmodule : runtime_pin_and_serial_option_regs_tb_top
